// ---- rtl/sysctl_top.sv ----
// Purpose: oscillator control, nmi status and sleep clock gating
// Assumes: apb slave with no wait states, all inputs synchronous
// Notes: event inputs are levels sampled every clock
`timescale 1ns/1ps

module sysctl_top
   import sysctl_pkg::*;
#(
   parameter int N = 32,
   parameter int OSC_TIMEOUT = OSC_FAIL_CYCLES
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic osc_activity,
   input wire logic tamper_evt,
   input wire logic wdog_a_evt,
   input wire logic wdog_b_evt,
   input wire logic power_evt,
   input wire logic nmi_pin,
   input wire logic [1:0] cpu_mode,
   output logic osc_power_on,
   output logic osc_range_high,
   output logic osc_single_ended_src,
   output logic cpu_reset_req,
   output logic irq,
   output logic nmi_req,
   output logic [N-1:0] periph_clk_en
);
   typedef struct packed {
      logic [OSC_CFG_W-1:0] osc_cfg;
      logic gate_en;
      logic [N-1:0] run_en;
      logic [N-1:0] slp_en;
      logic [N-1:0] dslp_en;
      logic [NMI_W-1:0] nmi;
      logic [INT_W-1:0] int_stat;
      logic [INT_W-1:0] int_mask;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic irq;
      logic nmi_req;
      logic pwr_on;
      logic [7:0] rst_cnt;
      logic rst_req;
      logic [N-1:0] clk_en;
   } state_t;
   state_t s_reg, s_next;

   logic fail_pulse;
   logic setup;
   logic access;
   logic wr;
   logic rd;
   logic [NMI_W-1:0] nmi_evt;

   gate_if #(.N(N)) g();

   // ==========================================
   // address decode, used for the error response
   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      case (a)
         OFS_OSC_CFG, OFS_GATE, OFS_RUN_EN, OFS_SLP_EN,
         OFS_DSLP_EN, OFS_NMI, OFS_INT_STAT, OFS_INT_MASK,
         OFS_OSC_STAT: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction

   function automatic logic [31:0] rd_mux(input state_t s,
      input logic [ADDR_W-1:0] a);
      logic [31:0] r;
      r = 32'h0000_0000;
      case (a)
         OFS_OSC_CFG: r[OSC_CFG_W-1:0] = s.osc_cfg;
         OFS_GATE: r[0] = s.gate_en;
         OFS_RUN_EN: r[N-1:0] = s.run_en;
         OFS_SLP_EN: r[N-1:0] = s.slp_en;
         OFS_DSLP_EN: r[N-1:0] = s.dslp_en;
         OFS_NMI: r[NMI_W-1:0] = s.nmi;
         OFS_INT_STAT: r[INT_W-1:0] = s.int_stat;
         OFS_INT_MASK: r[INT_W-1:0] = s.int_mask;
         OFS_OSC_STAT: r[1:0] = {s.rst_req, s.pwr_on};
         default: r = 32'h0000_0000;
      endcase
      return r;
   endfunction

   // ==========================================
   // oscillator loss detector, armed while detection is on and powered
   osc_monitor #(.TIMEOUT(OSC_TIMEOUT)) u_mon (
      .clk(clk),
      .rst_b(rst_b),
      .enable(s_reg.osc_cfg[B_DETECT] & s_reg.pwr_on),
      .osc_activity(osc_activity),
      .fail_pulse(fail_pulse)
   );

   // ==========================================
   // per-peripheral clock enable decoder
   assign g.gate_en = s_reg.gate_en;
   assign g.mode = cpu_mode;
   assign g.run_en = s_reg.run_en;
   assign g.slp_en = s_reg.slp_en;
   assign g.dslp_en = s_reg.dslp_en;

   periph_gate #(.N(N)) u_gate (
      .g(g)
   );

   // ==========================================
   // apb phase decode
   assign setup = psel & ~penable;
   assign access = psel & penable & s_reg.pready;
   assign wr = access & pwrite & ~s_reg.pslverr;
   assign rd = access & ~pwrite & ~s_reg.pslverr;
   assign nmi_evt = {nmi_pin, power_evt, wdog_b_evt, wdog_a_evt,
      tamper_evt, fail_pulse};

   // ==========================================
   // next state of the whole block
   always_comb begin
      s_next = s_reg;
      // bus answer: data captured at setup, ready in access
      s_next.pready = setup;
      s_next.pslverr = setup & ~is_mapped(paddr);
      s_next.prdata = (setup & ~pwrite) ? rd_mux(s_reg, paddr)
         : 32'h0000_0000;
      // software writes
      if (wr) begin
         case (paddr)
            OFS_OSC_CFG: begin
               s_next.osc_cfg = pwdata[OSC_CFG_W-1:0];
            end
            OFS_GATE: s_next.gate_en = pwdata[0];
            OFS_RUN_EN: s_next.run_en = pwdata[N-1:0];
            OFS_SLP_EN: s_next.slp_en = pwdata[N-1:0];
            OFS_DSLP_EN: s_next.dslp_en = pwdata[N-1:0];
            OFS_NMI: begin
               s_next.nmi = s_reg.nmi & ~pwdata[NMI_W-1:0];
            end
            OFS_INT_MASK: s_next.int_mask = pwdata[INT_W-1:0];
            default: s_next.int_mask = s_reg.int_mask;
         endcase
      end
      // read of status clears only the bits it returned
      if (rd && paddr == OFS_INT_STAT) begin
         s_next.int_stat = s_reg.int_stat & ~s_reg.prdata[INT_W-1:0];
      end
      // events set after clears so that set wins
      s_next.nmi = s_next.nmi | nmi_evt;
      if (|nmi_evt) begin
         s_next.int_stat[B_INT_NMI] = 1'b1;
      end
      if (fail_pulse && s_reg.osc_cfg[B_IRQ]) begin
         s_next.int_stat[B_INT_OSC] = 1'b1;
      end
      // processor reset pulse on failure without irq option
      if (fail_pulse && !s_reg.osc_cfg[B_IRQ]) begin
         s_next.rst_cnt = 8'(RST_PULSE_CYCLES);
      end else if (s_reg.rst_cnt != 8'h00) begin
         s_next.rst_cnt = s_reg.rst_cnt - 8'h01;
      end
      s_next.rst_req = s_next.rst_cnt != 8'h00;
      // oscillator power follows absent and power-off options
      s_next.pwr_on = ~(s_next.osc_cfg[B_ABSENT]
         | s_next.osc_cfg[B_PWR_OFF]);
      s_next.irq = |(s_next.int_stat & s_next.int_mask);
      s_next.nmi_req = |s_next.nmi;
      s_next.clk_en = g.clk_en;
   end

   // ==========================================
   // state register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_reg <= '0;
         s_reg.osc_cfg <= OSC_CFG_RST;
         s_reg.pwr_on <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   // ==========================================
   // outputs, each from the state register
   assign prdata = s_reg.prdata;
   assign pready = s_reg.pready;
   assign pslverr = s_reg.pslverr;
   assign osc_power_on = s_reg.pwr_on;
   assign osc_range_high = s_reg.osc_cfg[B_RANGE_HIGH];
   assign osc_single_ended_src = s_reg.osc_cfg[B_SE_SRC];
   assign cpu_reset_req = s_reg.rst_req;
   assign irq = s_reg.irq;
   assign nmi_req = s_reg.nmi_req;
   assign periph_clk_en = s_reg.clk_en;

   // ==========================================
   // checks
   sequence s_nmi_wr;
      wr && paddr == OFS_NMI;
   endsequence

   sequence s_fail_rst;
      cpu_reset_req [*8];
   endsequence

   property p_detect_gate;
      @(posedge clk) disable iff (!rst_b)
      fail_pulse |-> $past(s_reg.osc_cfg[B_DETECT]);
   endproperty
   a_detect_gate: assert property (p_detect_gate)
      else $error("fail seen with detection off");

   property p_fail_irq;
      @(posedge clk) disable iff (!rst_b)
      (fail_pulse && s_reg.osc_cfg[B_IRQ]
         && s_reg.int_mask[B_INT_OSC] && !wr)
      |-> ##1 (s_reg.int_stat[B_INT_OSC] && irq);
   endproperty
   a_fail_irq: assert property (p_fail_irq)
      else $error("osc fail did not raise irq");

   property p_fail_rst;
      @(posedge clk) disable iff (!rst_b)
      (fail_pulse && !s_reg.osc_cfg[B_IRQ]) |-> ##1 s_fail_rst;
   endproperty
   a_fail_rst: assert property (p_fail_rst)
      else $error("osc fail did not reset processor");

   property p_power;
      @(posedge clk) disable iff (!rst_b)
      osc_power_on == !(s_reg.osc_cfg[B_ABSENT]
         || s_reg.osc_cfg[B_PWR_OFF]);
   endproperty
   a_power: assert property (p_power)
      else $error("oscillator power wrong");

   property p_nmi_read;
      @(posedge clk) disable iff (!rst_b)
      (setup && !pwrite && paddr == OFS_NMI)
      |=> prdata[NMI_W-1:0] == $past(s_reg.nmi) && pready;
   endproperty
   a_nmi_read: assert property (p_nmi_read)
      else $error("nmi status read wrong");

   property p_nmi_clear;
      @(posedge clk) disable iff (!rst_b)
      s_nmi_wr |=> s_reg.nmi == (($past(s_reg.nmi)
         & ~$past(pwdata[NMI_W-1:0])) | $past(nmi_evt));
   endproperty
   a_nmi_clear: assert property (p_nmi_clear)
      else $error("nmi clear touched wrong flags");

   property p_nmi_sticky;
      @(posedge clk) disable iff (!rst_b)
      (s_reg.nmi != 6'h00 && !(wr && paddr == OFS_NMI))
      |=> (s_reg.nmi & $past(s_reg.nmi)) == $past(s_reg.nmi);
   endproperty
   a_nmi_sticky: assert property (p_nmi_sticky)
      else $error("nmi flag dropped without clear");

   property p_gate_off;
      @(posedge clk) disable iff (!rst_b)
      !s_reg.gate_en |=> periph_clk_en == $past(s_reg.run_en);
   endproperty
   a_gate_off: assert property (p_gate_off)
      else $error("clocks differ from run with gating off");

   property p_deep;
      @(posedge clk) disable iff (!rst_b)
      (s_reg.gate_en && cpu_mode == MODE_DEEP)
      |=> periph_clk_en == $past(s_reg.run_en & s_reg.dslp_en);
   endproperty
   a_deep: assert property (p_deep)
      else $error("deep sleep clocks wrong");

   property p_wake;
      @(posedge clk) disable iff (!rst_b)
      ($past(cpu_mode) == MODE_DEEP && cpu_mode == MODE_RUN)
      |=> periph_clk_en == $past(s_reg.run_en);
   endproperty
   a_wake: assert property (p_wake)
      else $error("peripheral not resumed on wake");

   property p_irq_mask;
      @(posedge clk) disable iff (!rst_b)
      ##1 irq == |(s_reg.int_stat & s_reg.int_mask);
   endproperty
   a_irq_mask: assert property (p_irq_mask)
      else $error("irq does not match masked status");

   property p_sleep;
      @(posedge clk) disable iff (!rst_b)
      (s_reg.gate_en && cpu_mode == MODE_SLEEP)
      |=> periph_clk_en == $past(s_reg.run_en & s_reg.slp_en);
   endproperty
   a_sleep: assert property (p_sleep)
      else $error("sleep clocks wrong");

   property p_irq_no_reset;
      @(posedge clk) disable iff (!rst_b)
      (fail_pulse && s_reg.osc_cfg[B_IRQ] && !cpu_reset_req)
      |=> !cpu_reset_req;
   endproperty
   a_irq_no_reset: assert property (p_irq_no_reset)
      else $error("irq mode requested a processor reset");

   property p_nmi_set;
      @(posedge clk) disable iff (!rst_b)
      (nmi_evt != 6'h00)
      |=> (s_reg.nmi & $past(nmi_evt)) == $past(nmi_evt) && nmi_req;
   endproperty
   a_nmi_set: assert property (p_nmi_set)
      else $error("nmi event did not set its flag");

   property p_bus_err;
      @(posedge clk) disable iff (!rst_b)
      (setup && !is_mapped(paddr))
      |=> pready && pslverr && prdata == 32'h0000_0000;
   endproperty
   a_bus_err: assert property (p_bus_err)
      else $error("unmapped access not refused");
endmodule

// ---- rtl/sysctl_pkg.sv ----
// Purpose: shared constants for the system control block
// Assumes: 32-bit apb data, one word per register
// Notes: all offsets are byte addresses
package sysctl_pkg;
   // ==========================================
   // register map
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFS_OSC_CFG = 8'h00;
   localparam logic [7:0] OFS_GATE = 8'h04;
   localparam logic [7:0] OFS_RUN_EN = 8'h08;
   localparam logic [7:0] OFS_SLP_EN = 8'h0C;
   localparam logic [7:0] OFS_DSLP_EN = 8'h10;
   localparam logic [7:0] OFS_NMI = 8'h14;
   localparam logic [7:0] OFS_INT_STAT = 8'h18;
   localparam logic [7:0] OFS_INT_MASK = 8'h1C;
   localparam logic [7:0] OFS_OSC_STAT = 8'h20;
   // ==========================================
   // oscillator configuration fields
   localparam int OSC_CFG_W = 6;
   localparam int B_DETECT = 0;
   localparam int B_IRQ = 1;
   localparam int B_ABSENT = 2;
   localparam int B_PWR_OFF = 3;
   localparam int B_RANGE_HIGH = 4;
   localparam int B_SE_SRC = 5;
   localparam logic [5:0] OSC_CFG_RST = 6'h00;
   // ==========================================
   // nmi and interrupt status fields
   localparam int NMI_W = 6;
   localparam int B_NMI_OSC = 0;
   localparam int B_NMI_TAMPER = 1;
   localparam int B_NMI_WDA = 2;
   localparam int B_NMI_WDB = 3;
   localparam int B_NMI_PWR = 4;
   localparam int B_NMI_PIN = 5;
   localparam int INT_W = 2;
   localparam int B_INT_OSC = 0;
   localparam int B_INT_NMI = 1;
   // ==========================================
   // processor power modes
   localparam logic [1:0] MODE_RUN = 2'h0;
   localparam logic [1:0] MODE_SLEEP = 2'h1;
   localparam logic [1:0] MODE_DEEP = 2'h2;
   // ==========================================
   // timing
   localparam int CLK_PERIOD_PS = 4000;
   localparam int OSC_FAIL_NS = 1000;
   localparam int OSC_FAIL_CYCLES =
      (OSC_FAIL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int RST_PULSE_NS = 64;
   localparam int RST_PULSE_CYCLES =
      (RST_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
endpackage

// ---- rtl/gate_if.sv ----
// Purpose: carries gating settings to the clock gate decoder
// Assumes: one clock domain
// Notes: clk_en is combinational from the decoder
`timescale 1ns/1ps
interface gate_if #(parameter int N = 32);
   logic gate_en;
   logic [1:0] mode;
   logic [N-1:0] run_en;
   logic [N-1:0] slp_en;
   logic [N-1:0] dslp_en;
   logic [N-1:0] clk_en;
   modport ctrl(output gate_en, mode, run_en, slp_en, dslp_en,
      input clk_en);
   modport gate(input gate_en, mode, run_en, slp_en, dslp_en,
      output clk_en);
endinterface

// ---- rtl/periph_gate.sv ----
// Purpose: per-peripheral clock enable from mode and settings
// Assumes: mode is one of the package mode codes
// Notes: a stopped peripheral keeps its state, clock only
`timescale 1ns/1ps
module periph_gate
   import sysctl_pkg::*;
#(
   parameter int N = 32
) (
   gate_if.gate g
);
   // ==========================================
   // decode one peripheral
   function automatic logic en_of(input logic [1:0] mode,
      input logic gate, input logic run, input logic slp,
      input logic dslp);
      logic r;
      r = run;
      if (gate) begin
         case (mode)
            MODE_SLEEP: r = run & slp;
            MODE_DEEP: r = run & dslp;
            default: r = run;
         endcase
      end
      return r;
   endfunction

   // ==========================================
   // one decoder per peripheral
   for (genvar i = 0; i < N; i++) begin : g_p
      assign g.clk_en[i] = en_of(g.mode, g.gate_en, g.run_en[i],
         g.slp_en[i], g.dslp_en[i]);
   end
endmodule

// ---- rtl/osc_monitor.sv ----
// Purpose: flags a main oscillator that stops toggling
// Assumes: osc_activity toggles, already synchronous to clk
// Notes: one fail pulse per loss; rearms when activity returns
`timescale 1ns/1ps
module osc_monitor
   import sysctl_pkg::*;
#(
   parameter int TIMEOUT = OSC_FAIL_CYCLES
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic enable,
   input wire logic osc_activity,
   output logic fail_pulse
);
   typedef struct packed {
      logic last;
      logic [15:0] cnt;
      logic failed;
      logic pulse;
   } mon_t;
   mon_t s_reg, s_next;

   // ==========================================
   // count cycles without an activity edge
   always_comb begin
      s_next = s_reg;
      s_next.last = osc_activity;
      s_next.pulse = 1'b0;
      if (!enable || osc_activity != s_reg.last) begin
         s_next.cnt = 16'h0000;
         s_next.failed = 1'b0;
      end else if (!s_reg.failed) begin
         if (s_reg.cnt == 16'(TIMEOUT - 1)) begin
            s_next.failed = 1'b1;
            s_next.pulse = 1'b1;
         end else begin
            s_next.cnt = s_reg.cnt + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign fail_pulse = s_reg.pulse;
endmodule

// ---- tb/testbench.sv ----
// Purpose: self-checking bench for the system control block
// Assumes: apb master acting just after the rising edge
// Notes: short oscillator timeout; assertions live in the design
`timescale 1ns/1ps
module testbench
   import sysctl_pkg::*;
;
   localparam int TMO = 8;
   logic clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, periph_clk_en;
   logic osc_activity, osc_run, osc_power_on, osc_range_high;
   logic osc_single_ended_src, cpu_reset_req, irq, nmi_req;
   logic [4:0] evt;
   logic [1:0] cpu_mode;
   int n_fail, n_compared;

   // ==========================================
   // design and clocks
   sysctl_top #(.N(32), .OSC_TIMEOUT(TMO)) u_dut (
      .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .osc_activity(osc_activity), .tamper_evt(evt[0]),
      .wdog_a_evt(evt[1]), .wdog_b_evt(evt[2]), .power_evt(evt[3]),
      .nmi_pin(evt[4]), .cpu_mode(cpu_mode),
      .osc_power_on(osc_power_on), .osc_range_high(osc_range_high),
      .osc_single_ended_src(osc_single_ended_src),
      .cpu_reset_req(cpu_reset_req), .irq(irq), .nmi_req(nmi_req),
      .periph_clk_en(periph_clk_en));

   // 250 MHz system clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // oscillator activity toggles only while the bench lets it run
   always @(posedge clk) begin
      if (osc_run) begin
         osc_activity <= ~osc_activity;
      end
   end

   // ==========================================
   // shared tasks
   task automatic complete_run();
      $display("compared %0d, mismatched %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
      input string what);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // one apb transfer: setup, then access until pready
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int k;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) begin
         n_fail++;
         $display("BAD t=%0t no pready", $time);
         complete_run();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
      input string what);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, e, what);
   endtask

   // bounded wait for irq (0) or reset request (1)
   task automatic wait_hi(input int sel);
      int k;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while ((sel == 0 ? irq : cpu_reset_req) !== 1'b1 && k < 80);
      if ((sel == 0 ? irq : cpu_reset_req) !== 1'b1) begin
         n_fail++;
         $display("BAD t=%0t wait ran out", $time);
         complete_run();
      end
   endtask

   task automatic mode_chk(input logic [1:0] m, input logic [31:0] e);
      cpu_mode <= m;
      wait_cyc(3);
      chk(periph_clk_en, e, "clock enables");
   endtask

   // ==========================================
   // scenarios
   task automatic t_reset();
      chk(osc_power_on, 1'b1, "power after reset");
      chk({cpu_reset_req, irq, nmi_req}, 3'b000, "idle outs");
      rdchk(OFS_NMI, 32'h0000_0000, "nmi after reset");
      chk(periph_clk_en, 32'h0000_0000, "clocks after reset");
      $display("test reset done");
   endtask

   task automatic t_cfg();
      wr(OFS_OSC_CFG, 32'h0000_0038);
      wait_cyc(2);
      chk({osc_power_on, osc_range_high, osc_single_ended_src}, 3'b011,
         "power off, high, single");
      rdchk(OFS_OSC_CFG, 32'h0000_0038, "cfg back");
      wr(OFS_OSC_CFG, 32'h0000_0004);
      wait_cyc(2);
      chk({osc_power_on, osc_range_high, osc_single_ended_src}, 3'b000,
         "absent, low, xtal");
      rdchk(OFS_OSC_CFG, 32'h0000_0004, "absent back");
      wr(OFS_OSC_CFG, 32'h0000_0000);
      wait_cyc(2);
      chk(osc_power_on, 1'b1, "powered again");
      apb(1'b0, 8'h40, 32'h0000_0000);
      chk(err, 1'b1, "unmapped error");
      chk(rd, 32'h0000_0000, "unmapped data");
      $display("test cfg done");
   endtask

   task automatic t_nmi();
      int i;
      logic [5:0] acc;
      acc = 6'h00;
      for (i = 0; i < 5; i++) begin
         evt <= 5'(1 << i);
         @(posedge clk);
         evt <= 5'h00;
         wait_cyc(3);
         acc[i+1] = 1'b1;
         rdchk(OFS_NMI, 32'(acc), "flag kept");
      end
      chk(nmi_req, 1'b1, "nmi request");
      chk(irq, 1'b0, "masked source");
      wr(OFS_INT_MASK, 32'h0000_0002);
      wait_cyc(2);
      chk(irq, 1'b1, "unmasked source");
      apb(1'b0, OFS_INT_STAT, 32'h0000_0000);
      chk(rd[1], 1'b1, "raw status");
      wait_cyc(2);
      chk(irq, 1'b0, "status read clears");
      wr(OFS_NMI, 32'h0000_000A);
      rdchk(OFS_NMI, 32'h0000_0034, "partial clear");
      wr(OFS_NMI, 32'h0000_0034);
      rdchk(OFS_NMI, 32'h0000_0000, "full clear");
      chk(nmi_req, 1'b0, "nmi request gone");
      wr(OFS_INT_MASK, 32'h0000_0000);
      $display("test nmi done");
   endtask

   task automatic t_osc();
      int n;
      osc_run <= 1'b0;
      wait_cyc(40);
      rdchk(OFS_NMI, 32'h0000_0000, "detection off");
      osc_run <= 1'b1;
      wait_cyc(4);
      wr(OFS_INT_MASK, 32'h0000_0001);
      wr(OFS_OSC_CFG, 32'h0000_0003);
      osc_run <= 1'b0;
      wait_hi(0);
      chk(cpu_reset_req, 1'b0, "irq mode no reset");
      rdchk(OFS_NMI, 32'h0000_0001, "osc flag");
      apb(1'b0, OFS_INT_STAT, 32'h0000_0000);
      chk(rd[0], 1'b1, "fail status");
      wr(OFS_NMI, 32'h0000_0001);
      osc_run <= 1'b1;
      wait_cyc(4);
      wr(OFS_OSC_CFG, 32'h0000_0001);
      osc_run <= 1'b0;
      wait_hi(1);
      n = 0;
      while (cpu_reset_req === 1'b1 && n < 40) begin
         @(posedge clk);
         n++;
      end
      chk(n, RST_PULSE_CYCLES, "reset pulse length");
      chk(irq, 1'b0, "reset mode no irq");
      osc_run <= 1'b1;
      wait_cyc(4);
      wr(OFS_OSC_CFG, 32'h0000_0000);
      wr(OFS_NMI, 32'h0000_003F);
      $display("test osc done");
   endtask

   task automatic t_gate();
      wr(OFS_RUN_EN, 32'h0000_00FF);
      wr(OFS_SLP_EN, 32'h0000_000F);
      wr(OFS_DSLP_EN, 32'h0000_0003);
      mode_chk(MODE_SLEEP, 32'h0000_00FF);
      mode_chk(MODE_DEEP, 32'h0000_00FF);
      wr(OFS_GATE, 32'h0000_0001);
      mode_chk(MODE_SLEEP, 32'h0000_000F);
      mode_chk(MODE_DEEP, 32'h0000_0003);
      mode_chk(MODE_RUN, 32'h0000_00FF);
      rdchk(OFS_DSLP_EN, 32'h0000_0003, "deep kept");
      $display("test gate done");
   endtask

   // ==========================================
   // main sequence
   initial begin
      rst_b = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      evt = 5'h00;
      cpu_mode = MODE_RUN;
      osc_run = 1'b1;
      osc_activity = 1'b0;
      n_fail = 0;
      n_compared = 0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      t_reset();
      t_cfg();
      t_nmi();
      t_osc();
      t_gate();
      complete_run();
   end
endmodule
